// ### core/emap_arbiter.sv
// Picks the pending entry of lowest rank, the lowest index winning a tie.
`timescale 1ns/1ps
`default_nettype none
`include "emap_cfg.svh"

module emap_arbiter (
    // Candidates.
    input wire logic [70:0] i_valid,
    input wire logic [283:0] i_rank,
    // Winner.
    output logic o_found,
    output emap_pkg::emap_num_t o_num,
    output emap_pkg::emap_rank_t o_rank
);
    import emap_pkg::*;

    // A strict less-than keeps the earlier, lower-numbered entry on a tie.
    always_comb begin
        o_found = 1'b0;
        o_num = 7'h00;
        o_rank = `EMAP_RANK_NONE;
        for (int i = 0; i < `EMAP_NUM_ENTRY; i++) begin
            if (i_valid[i] && (!o_found || (i_rank[i*4 +: 4] < o_rank))) begin
                o_found = 1'b1;
                o_num = 7'(i);
                o_rank = i_rank[i*4 +: 4];
            end
        end
    end

endmodule
`default_nettype wire

// ### core/emap_sys_exc.sv
// Pending state of the core's system exceptions, with fault escalation.
`timescale 1ns/1ps
`default_nettype none
`include "emap_cfg.svh"

module emap_sys_exc (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Exception events, one-cycle pulses from core logic.
    input wire logic i_fault_mem,
    input wire logic i_fault_bus,
    input wire logic i_fault_usage,
    input wire logic [2:0] i_fault_handler_en,
    input wire logic i_svc_exec,
    input wire logic i_debug_event,
    input wire logic i_defer_set,
    input wire logic i_tick,
    // Clear of one pending exception when the core takes it.
    input wire logic i_take,
    input wire emap_pkg::emap_num_t i_take_num,
    // Pending exceptions, indexed by exception number.
    output logic [15:0] o_pending
);
    import emap_pkg::*;

    logic [15:0] pend_r;
    logic [15:0] pend_nxt;
    logic [15:0] set_v;

    // Sets win over the take clear so a fault in the take cycle is kept.
    always_comb begin
        set_v = 16'h0000;
        set_v[`EMAP_EXC_MEM] = i_fault_mem & i_fault_handler_en[0];
        set_v[`EMAP_EXC_BUS] = i_fault_bus & i_fault_handler_en[1];
        set_v[`EMAP_EXC_USAGE] = i_fault_usage & i_fault_handler_en[2];
        set_v[`EMAP_EXC_HARD] = (i_fault_mem & ~i_fault_handler_en[0]) | (i_fault_bus & ~i_fault_handler_en[1])
            | (i_fault_usage & ~i_fault_handler_en[2]);
        set_v[`EMAP_EXC_SVC] = i_svc_exec;
        set_v[`EMAP_EXC_DEBUG] = i_debug_event;
        set_v[`EMAP_EXC_DEFER] = i_defer_set;
        set_v[`EMAP_EXC_TICK] = i_tick;
        pend_nxt = pend_r;
        if (i_take && (i_take_num < 7'(`EMAP_NUM_SYS))) begin
            pend_nxt[i_take_num[3:0]] = 1'b0;
        end
        pend_nxt = pend_nxt | set_v;
        pend_nxt[`EMAP_EXC_NMI] = 1'b0;
    end

    // The reset exception is pending after every reset until the core takes it.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            pend_r <= 16'h0002;
        end else if (i_clk_en) begin
            pend_r <= pend_nxt;
        end
    end

    assign o_pending = pend_r;

endmodule
`default_nettype wire

// ### core/emap_top.sv
// Exception and peripheral interrupt map with wake-up qualification per power mode.
`timescale 1ns/1ps
`default_nettype none
`include "emap_cfg.svh"

// Operation
// - Reset exception 1 has fixed priority -3; exception 2 exists but never fires.
// - A fault whose own handler is disabled escalates to hard fault 3, priority -1.
// - An access to an invalid location raises exception 4, programmable priority.
// - Prefetch, memory access, data abort and address faults raise exception 5.
// - Undefined instruction or invalid state transition raises exception 6.
// - The system service call instruction raises exception 11.
// - Breakpoints, watchpoints and external debug requests raise exception 12.
// - Exception 14 defers service calls, 15 is the tick; 7-10 and 13 reserved.
// - Every peripheral source may wake the device from Mode 1.
// - Only positions 0 to 10, less 4 and 7, wake from Mode 2 or 3.
// - A wake from Mode 2 or Mode 3 resumes in Mode 0.
// - Sleeping inside a handler, only a higher-priority source may wake.
// - Transfer channels 0 to 13 complete at positions 26 to 39; error at 25.
// - Positions 4, 7, 11, 12, 40-43 stay empty; 44-54 carry the upper group.
// - Three priority bits, eight levels, default 0; lower position wins ties.
module emap_top (
    // Clock, reset and clock enable.
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Peripheral request pulses, from logic on this clock.
    input wire logic i_wake_timer,
    input wire logic [8:0] i_ext_irq,
    input wire logic i_watchdog,
    input wire logic [11:0] i_periph_lo,
    input wire logic i_xfer_err,
    input wire logic [13:0] i_xfer_done,
    input wire logic [10:0] i_periph_hi,
    // Per-position enable and priority level, three bits per position.
    input wire logic [54:0] i_periph_en,
    input wire logic [164:0] i_periph_prio,
    // Core-side exception events.
    input wire logic i_fault_mem,
    input wire logic i_fault_bus,
    input wire logic i_fault_usage,
    input wire logic [2:0] i_fault_handler_en,
    input wire logic i_svc_exec,
    input wire logic i_debug_event,
    input wire logic i_defer_set,
    input wire logic i_tick,
    input wire logic [20:0] i_sys_prio,
    // Core acknowledge of a taken exception.
    input wire logic i_take,
    input wire emap_pkg::emap_num_t i_take_num,
    // Sleep request and handler state from the core.
    input wire logic i_sleep_req,
    input wire emap_pkg::emap_mode_t i_sleep_mode,
    input wire logic i_handler_active,
    input wire emap_pkg::emap_prio_t i_active_prio,
    // Pending and arbitration results.
    output logic [54:0] o_periph_pending,
    output logic [15:0] o_sys_pending,
    output logic o_exc_valid,
    output emap_pkg::emap_num_t o_exc_num,
    output emap_pkg::emap_rank_t o_exc_rank,
    // Power mode and wake.
    output emap_pkg::emap_mode_t o_power_mode,
    output logic o_wake
);
    import emap_pkg::*;

    // Named copies of the masks, so that single positions can be picked out of them.
    localparam logic [54:0] RSV_MASK = `EMAP_RESERVED_MASK;
    localparam logic [54:0] DEEP_MASK = `EMAP_DEEP_WAKE_MASK;

    logic [54:0] raw_req;
    logic [54:0] pend_r;
    logic [54:0] pend_nxt;
    logic [15:0] sys_pend;
    logic [70:0] arb_valid;
    logic [283:0] arb_rank;
    logic arb_found;
    emap_num_t arb_num;
    emap_rank_t arb_rank_win;
    logic [54:0] wake_qual;
    logic wake_hit;
    emap_mode_t mode_r;
    emap_mode_t mode_nxt;
    logic in_handler_r;
    logic in_handler_nxt;
    emap_prio_t sleep_prio_r;
    emap_prio_t sleep_prio_nxt;
    logic wake_r;
    logic wake_nxt;
    logic exc_valid_r;
    logic exc_valid_nxt;
    emap_num_t exc_num_r;
    emap_num_t exc_num_nxt;
    emap_rank_t exc_rank_r;
    emap_rank_t exc_rank_nxt;

    // Request vector from every source by position; ext lines 3 and 6 fall on reserved positions.
    always_comb begin
        raw_req = 55'h00_0000_0000_0000;
        raw_req[`EMAP_POS_WAKE_TIMER] = i_wake_timer;
        raw_req[`EMAP_POS_EXT_BASE +: `EMAP_NUM_EXT] = i_ext_irq;
        raw_req[`EMAP_POS_WATCHDOG] = i_watchdog;
        raw_req[`EMAP_POS_LO_BASE +: `EMAP_NUM_LO] = i_periph_lo;
        raw_req[`EMAP_POS_XFER_ERR] = i_xfer_err;
        raw_req[`EMAP_POS_XFER_DONE_BASE +: `EMAP_NUM_XFER_CH] = i_xfer_done;
        raw_req[`EMAP_POS_HI_BASE +: `EMAP_NUM_HI] = i_periph_hi;
        raw_req = raw_req & ~`EMAP_RESERVED_MASK;
    end

    // Each position holds its request until the core takes it; a new request wins over the take.
    genvar gp;
    generate
        for (gp = 0; gp < `EMAP_NUM_PERIPH; gp++) begin : g_pend
            logic take_here;
            assign take_here = i_take && (i_take_num == 7'(gp + `EMAP_PERIPH_BASE));
            assign pend_nxt[gp] = raw_req[gp] | (pend_r[gp] & ~take_here);
        end
    endgenerate

    // Pending register for the peripheral positions.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            pend_r <= 55'h00_0000_0000_0000;
        end else if (i_clk_en) begin
            pend_r <= pend_nxt;
        end
    end

    // System exception pending state.
    emap_sys_exc u_sys_exc (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_clk_en(i_clk_en),
        .i_fault_mem(i_fault_mem),
        .i_fault_bus(i_fault_bus),
        .i_fault_usage(i_fault_usage),
        .i_fault_handler_en(i_fault_handler_en),
        .i_svc_exec(i_svc_exec),
        .i_debug_event(i_debug_event),
        .i_defer_set(i_defer_set),
        .i_tick(i_tick),
        .i_take(i_take),
        .i_take_num(i_take_num),
        .o_pending(sys_pend)
    );

    // Candidate ranks: fixed levels for reset, NMI and hard fault, then eight programmable levels.
    // The programmable system exceptions take their levels from i_sys_prio in exception order
    // 4, 5, 6, 11, 12, 14, 15; reserved numbers never become valid.
    always_comb begin
        arb_valid = {pend_r & i_periph_en, sys_pend};
        arb_valid[`EMAP_EXC_NMI] = 1'b0;
        arb_valid[10:7] = 4'h0;
        arb_valid[13] = 1'b0;
        arb_valid[0] = 1'b0;
        arb_rank = {284{1'b1}};
        arb_rank[`EMAP_EXC_RESET*4 +: 4] = `EMAP_RANK_RESET;
        arb_rank[`EMAP_EXC_NMI*4 +: 4] = `EMAP_RANK_NMI;
        arb_rank[`EMAP_EXC_HARD*4 +: 4] = `EMAP_RANK_HARD;
        arb_rank[`EMAP_EXC_MEM*4 +: 4] = {`EMAP_RANK_PROG_BASE, i_sys_prio[2:0]};
        arb_rank[`EMAP_EXC_BUS*4 +: 4] = {`EMAP_RANK_PROG_BASE, i_sys_prio[5:3]};
        arb_rank[`EMAP_EXC_USAGE*4 +: 4] = {`EMAP_RANK_PROG_BASE, i_sys_prio[8:6]};
        arb_rank[`EMAP_EXC_SVC*4 +: 4] = {`EMAP_RANK_PROG_BASE, i_sys_prio[11:9]};
        arb_rank[`EMAP_EXC_DEBUG*4 +: 4] = {`EMAP_RANK_PROG_BASE, i_sys_prio[14:12]};
        arb_rank[`EMAP_EXC_DEFER*4 +: 4] = {`EMAP_RANK_PROG_BASE, i_sys_prio[17:15]};
        arb_rank[`EMAP_EXC_TICK*4 +: 4] = {`EMAP_RANK_PROG_BASE, i_sys_prio[20:18]};
        for (int p = 0; p < `EMAP_NUM_PERIPH; p++) begin
            arb_rank[(p + `EMAP_PERIPH_BASE)*4 +: 4] = {`EMAP_RANK_PROG_BASE, i_periph_prio[p*3 +: 3]};
        end
    end

    // Fixed-order winner search over all exceptions.
    emap_arbiter u_arbiter (
        .i_valid(arb_valid),
        .i_rank(arb_rank),
        .o_found(arb_found),
        .o_num(arb_num),
        .o_rank(arb_rank_win)
    );

    // Wake qualification: the mode decides the eligible set, the handler level filters it.
    // A lower level value means higher priority, so only a strictly smaller value gets through.
    always_comb begin
        for (int q = 0; q < `EMAP_NUM_PERIPH; q++) begin
            wake_qual[q] = pend_r[q] & i_periph_en[q];
            if (mode_r == EMAP_MODE1) begin
                wake_qual[q] = wake_qual[q] & ~RSV_MASK[q];
            end else begin
                wake_qual[q] = wake_qual[q] & DEEP_MASK[q];
            end
            if (in_handler_r && (i_periph_prio[q*3 +: 3] >= sleep_prio_r)) begin
                wake_qual[q] = 1'b0;
            end
        end
        wake_hit = (mode_r != EMAP_MODE0) && (wake_qual != 55'h00_0000_0000_0000);
    end

    // Power mode sequence: sleep from Mode 0 into the requested mode, wake back to Mode 0.
    always_comb begin
        mode_nxt = mode_r;
        in_handler_nxt = in_handler_r;
        sleep_prio_nxt = sleep_prio_r;
        wake_nxt = 1'b0;
        case (mode_r)
            EMAP_MODE0: begin
                if (i_sleep_req && (i_sleep_mode != EMAP_MODE0)) begin
                    mode_nxt = i_sleep_mode;
                    in_handler_nxt = i_handler_active;
                    sleep_prio_nxt = i_active_prio;
                end
            end
            EMAP_MODE1, EMAP_MODE2, EMAP_MODE3: begin
                if (wake_hit) begin
                    mode_nxt = EMAP_MODE0;
                    in_handler_nxt = 1'b0;
                    wake_nxt = 1'b1;
                end
            end
            default: begin
                mode_nxt = EMAP_MODE0;
                in_handler_nxt = 1'b0;
            end
        endcase
    end

    // Registers of the power mode sequence.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            mode_r <= EMAP_MODE0;
            in_handler_r <= 1'b0;
            sleep_prio_r <= `EMAP_PRIO_DEFAULT;
            wake_r <= 1'b0;
        end else if (i_clk_en) begin
            mode_r <= mode_nxt;
            in_handler_r <= in_handler_nxt;
            sleep_prio_r <= sleep_prio_nxt;
            wake_r <= wake_nxt;
        end
    end

    // Winner is registered so the outputs come from flops; it lags the pending state by one cycle.
    always_comb begin
        exc_valid_nxt = arb_found;
        exc_num_nxt = arb_num;
        exc_rank_nxt = arb_rank_win;
    end

    // Registers of the arbitration result.
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            exc_valid_r <= 1'b0;
            exc_num_r <= 7'h00;
            exc_rank_r <= `EMAP_RANK_NONE;
        end else if (i_clk_en) begin
            exc_valid_r <= exc_valid_nxt;
            exc_num_r <= exc_num_nxt;
            exc_rank_r <= exc_rank_nxt;
        end
    end

    // Outputs, all straight from registers.
    assign o_periph_pending = pend_r;
    assign o_sys_pending = sys_pend;
    assign o_exc_valid = exc_valid_r;
    assign o_exc_num = exc_num_r;
    assign o_exc_rank = exc_rank_r;
    assign o_power_mode = mode_r;
    assign o_wake = wake_r;

endmodule
`default_nettype wire

// ### shared/emap_cfg.svh
// Constants of the exception and wake-up map: vector positions, masks, exception numbers and ranks.
`ifndef EMAP_CFG_SVH
`define EMAP_CFG_SVH

// Peripheral vector positions.
`define EMAP_NUM_PERIPH 55
`define EMAP_NUM_ENTRY 71
`define EMAP_PERIPH_BASE 16
`define EMAP_PRIO_W 3
`define EMAP_RANK_W 4
`define EMAP_NUM_W 7
`define EMAP_POS_WAKE_TIMER 0
`define EMAP_POS_EXT_BASE 1
`define EMAP_NUM_EXT 9
`define EMAP_POS_WATCHDOG 10
`define EMAP_POS_LO_BASE 13
`define EMAP_NUM_LO 12
`define EMAP_POS_XFER_ERR 25
`define EMAP_POS_XFER_DONE_BASE 26
`define EMAP_NUM_XFER_CH 14
`define EMAP_POS_HI_BASE 44
`define EMAP_NUM_HI 11

// Positions with no source connected: 4, 7, 11, 12 and 40 to 43.
`define EMAP_RESERVED_MASK 55'h00_0F00_0000_1890
// Positions that may wake from the deep modes: 0 to 10 less 4 and 7.
`define EMAP_DEEP_WAKE_MASK 55'h00_0000_0000_076F

// System exception numbers.
`define EMAP_EXC_RESET 1
`define EMAP_EXC_NMI 2
`define EMAP_EXC_HARD 3
`define EMAP_EXC_MEM 4
`define EMAP_EXC_BUS 5
`define EMAP_EXC_USAGE 6
`define EMAP_EXC_SVC 11
`define EMAP_EXC_DEBUG 12
`define EMAP_EXC_DEFER 14
`define EMAP_EXC_TICK 15
`define EMAP_NUM_SYS 16

// Ranks: lower wins; fixed levels -3, -2, -1 sit below every programmable level.
`define EMAP_RANK_RESET 4'h0
`define EMAP_RANK_NMI 4'h1
`define EMAP_RANK_HARD 4'h2
`define EMAP_RANK_PROG_BASE 1'b1
`define EMAP_RANK_NONE 4'hF
`define EMAP_PRIO_DEFAULT 3'h0

`endif

// ### shared/emap_pkg.sv
// Types shared by the exception and wake-up map.
package emap_pkg;

    // Power modes; Gray codes in mode order 0, 1, 2, 3.
    typedef enum logic [1:0] {
        EMAP_MODE0 = 2'h0,
        EMAP_MODE1 = 2'h1,
        EMAP_MODE2 = 2'h3,
        EMAP_MODE3 = 2'h2
    } emap_mode_t;

    typedef logic [2:0] emap_prio_t;
    typedef logic [3:0] emap_rank_t;
    typedef logic [6:0] emap_num_t;

endpackage

// ### sim/emap_src_model.sv
// Behavioural peripheral sources, one request line per vector position.
`timescale 1ns/1ps
`default_nettype none
module emap_src_model (
    // Clock.
    input wire logic i_clk_sys,
    // Bench command: pulse the line of one position.
    input wire logic i_fire,
    input wire logic [5:0] i_pos,
    // Request lines by position.
    output logic [54:0] o_lines = 55'h0
);
    // Each line follows i_fire one cycle later, so it stays high for as long as the bench holds i_fire.
    always @(posedge i_clk_sys) begin
        o_lines <= i_fire ? (55'h1 << i_pos) : 55'h0;
    end
endmodule
`default_nettype wire

// ### sim/emap_top_checker.sv
// Port-level checks of the exception and wake-up map.
`timescale 1ns/1ps
`default_nettype none
`include "emap_cfg.svh"
module emap_top_checker (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_clk_en,
    // Watched inputs.
    input wire logic [13:0] i_xfer_done,
    input wire logic [54:0] i_periph_en,
    input wire logic i_fault_mem,
    input wire logic i_fault_bus,
    input wire logic i_fault_usage,
    input wire logic [2:0] i_fault_handler_en,
    input wire logic i_svc_exec,
    input wire logic i_take,
    // Watched outputs.
    input wire logic [54:0] o_periph_pending,
    input wire logic [15:0] o_sys_pending,
    input wire logic o_exc_valid,
    input wire emap_pkg::emap_num_t o_exc_num,
    input wire emap_pkg::emap_mode_t o_power_mode,
    input wire logic o_wake
);
    import emap_pkg::*;
    logic esc;
    // A fault whose own handler is off must land on the hard fault.
    assign esc = (i_fault_mem && !i_fault_handler_en[0]) || (i_fault_bus && !i_fault_handler_en[1])
        || (i_fault_usage && !i_fault_handler_en[2]);
    // One clock domain, so clocking and reset are declared once.
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    a_nmi_never_fires: assert property (!o_sys_pending[2] && !(o_exc_valid && o_exc_num == 7'h02))
        else $error("nmi seen");
    a_fault_escalates: assert property (i_clk_en && esc |=> o_sys_pending[3])
        else $error("no hard fault");
    a_mem_fault_own: assert property (i_clk_en && i_fault_mem && i_fault_handler_en[0] |=> o_sys_pending[4])
        else $error("no mem fault");
    a_svc_call_pends: assert property (i_clk_en && i_svc_exec |=> o_sys_pending[11])
        else $error("no svc");
    a_xfer_done_map: assert property (i_clk_en && i_xfer_done != 14'h0
        |=> (o_periph_pending[39:26] & $past(i_xfer_done)) == $past(i_xfer_done)) else $error("xfer map");
    a_reserved_empty: assert property ((o_periph_pending & `EMAP_RESERVED_MASK) == 55'h0)
        else $error("reserved pend");
    a_pend_until_take: assert property (($past(o_periph_pending) & ~o_periph_pending) != 55'h0
        |-> $past(i_take)) else $error("pend lost");
    a_wake_qualified: assert property (o_wake
        |-> ($past(o_periph_pending) & $past(i_periph_en)) != 55'h0 && $past(o_power_mode) != EMAP_MODE0)
        else $error("bad wake");
    a_deep_wake_mask: assert property (o_wake && $past(o_power_mode) inside {EMAP_MODE2, EMAP_MODE3}
        |-> ($past(o_periph_pending) & $past(i_periph_en) & `EMAP_DEEP_WAKE_MASK) != 55'h0)
        else $error("deep wake");
    a_wake_resumes_run: assert property (o_wake |-> o_power_mode == EMAP_MODE0 ##1 !o_wake)
        else $error("wake mode");
endmodule
`default_nettype wire

// ### sim/tb_exception_wakeup_map.sv
// Self-checking bench of the exception and wake-up map.
`timescale 1ns/1ps
`default_nettype none
`include "emap_cfg.svh"
module tb_exception_wakeup_map;
    import emap_pkg::*;
    localparam int SYS_NUM [7] = '{4, 5, 6, 11, 12, 14, 15};
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic fire = 1'b0;
    logic [5:0] pos = 6'h0;
    logic [54:0] src;
    logic [54:0] en = {55{1'b1}};
    logic [164:0] prio = 165'h0;
    logic [6:0] evt = 7'h0;
    logic [2:0] hen = 3'h7;
    logic [20:0] sprio = 21'h0;
    logic take = 1'b0;
    emap_num_t tnum = 7'h00;
    logic sreq = 1'b0;
    emap_mode_t smode = EMAP_MODE0;
    logic hact = 1'b0;
    logic cen = 1'b1;
    emap_prio_t aprio = 3'h2;
    logic [54:0] ppend;
    logic [15:0] spend;
    logic vld;
    logic wake;
    emap_num_t num;
    emap_rank_t rank;
    emap_mode_t mode;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int wakes = 0;
    int a, b, pa, pb, w;

    emap_src_model SRC (.i_clk_sys(i_clk_sys), .i_fire(fire), .i_pos(pos), .o_lines(src));
    emap_top DUT (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_clk_en(cen), .i_wake_timer(src[0]),
        .i_ext_irq(src[9:1]), .i_watchdog(src[10]), .i_periph_lo(src[24:13]), .i_xfer_err(src[25]),
        .i_xfer_done(src[39:26]), .i_periph_hi(src[54:44]), .i_periph_en(en), .i_periph_prio(prio),
        .i_fault_mem(evt[0]), .i_fault_bus(evt[1]), .i_fault_usage(evt[2]), .i_fault_handler_en(hen),
        .i_svc_exec(evt[3]), .i_debug_event(evt[4]), .i_defer_set(evt[5]), .i_tick(evt[6]),
        .i_sys_prio(sprio), .i_take(take), .i_take_num(tnum), .i_sleep_req(sreq), .i_sleep_mode(smode),
        .i_handler_active(hact), .i_active_prio(aprio), .o_periph_pending(ppend), .o_sys_pending(spend),
        .o_exc_valid(vld), .o_exc_num(num), .o_exc_rank(rank), .o_power_mode(mode), .o_wake(wake)
    );

    // Free-running system clock.
    initial forever #5 i_clk_sys = ~i_clk_sys;

    // Cycle ceiling against hangs.
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    // Wake pulses are counted at the falling edge, where the registered output has settled.
    always @(negedge i_clk_sys) begin
        if (wake === 1'b1) wakes++;
    end

    task automatic give_verdict();
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Outputs are read at the falling edge, well after the rising edge has landed.
    task automatic look(input int n);
        repeat (n) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask

    task automatic pulse(input int p);
        @(posedge i_clk_sys);
        fire <= 1'b1;
        pos <= p[5:0];
        @(posedge i_clk_sys);
        fire <= 1'b0;
    endtask

    task automatic grab(input int n);
        @(posedge i_clk_sys);
        take <= 1'b1;
        tnum <= n[6:0];
        @(posedge i_clk_sys);
        take <= 1'b0;
    endtask

    task automatic sys_ev(input int k);
        @(posedge i_clk_sys);
        evt <= 7'h01 << k;
        @(posedge i_clk_sys);
        evt <= 7'h00;
    endtask

    // Sleeps only from the run mode, fires one source, and checks whether it woke.
    task automatic nap(input emap_mode_t m, input logic h, input int p, input logic woke);
        if (mode === EMAP_MODE0) begin
            @(posedge i_clk_sys);
            sreq <= 1'b1;
            smode <= m;
            hact <= h;
            @(posedge i_clk_sys);
            sreq <= 1'b0;
        end
        pulse(p);
        look(2);
        chk(mode, woke ? EMAP_MODE0 : m);
        grab(16 + p);
    endtask

    function automatic int pick();
        int p;
        do p = $urandom_range(54); while (((`EMAP_RESERVED_MASK >> p) & 55'h1) != 55'h0);
        return p;
    endfunction

    function automatic emap_rank_t exp_rank(input int p);
        return 4'h8 + p[3:0];
    endfunction

    initial begin
        void'($urandom(43));
        repeat (5) @(posedge i_clk_sys);
        chk({spend, rank, mode}, {16'h0002, 4'hF, EMAP_MODE0});
        i_reset <= 1'b0;
        look(1);
        chk({vld, num, rank}, {1'b1, 7'h01, 4'h0});
        grab(1);
        pulse(4);
        pulse(7);
        look(2);
        chk({ppend, vld}, 56'h0);
        // With the clock enable low a request is not taken and nothing moves.
        @(posedge i_clk_sys);
        cen <= 1'b0;
        pulse(13);
        look(1);
        chk({ppend, vld}, 56'h0);
        @(posedge i_clk_sys);
        cen <= 1'b1;
        // Two sources pending at once; ties go to the lower position.
        for (int i = 0; i < 30; i++) begin
            a = pick();
            do b = pick(); while (b == a);
            pa = $urandom_range(7);
            pb = (i % 2 == 1) ? pa : $urandom_range(7);
            w = (pa < pb || (pa == pb && a < b)) ? a : b;
            @(posedge i_clk_sys);
            prio[3*a +: 3] <= pa[2:0];
            prio[3*b +: 3] <= pb[2:0];
            pulse(a);
            pulse(b);
            look(2);
            chk(ppend, (55'h1 << a) | (55'h1 << b));
            chk({num, rank}, {7'h10 + w[6:0], exp_rank(w == a ? pa : pb)});
            grab(16 + a);
            grab(16 + b);
            look(1);
            chk({ppend, vld}, 56'h0);
        end
        // Every system event with its handler on, then the faults with handlers off.
        for (int k = 0; k < 10; k++) begin
            pa = $urandom_range(7);
            @(posedge i_clk_sys);
            hen <= (k < 7) ? 3'h7 : 3'h0;
            if (k < 7) sprio[3*k +: 3] <= pa[2:0];
            sys_ev(k % 7);
            look(1);
            if (k < 7) chk({vld, num, rank}, {1'b1, SYS_NUM[k][6:0], exp_rank(pa)});
            else chk({vld, num, rank}, {1'b1, 7'h03, 4'h2});
            grab((k < 7) ? SYS_NUM[k] : 3);
        end
        @(posedge i_clk_sys);
        prio[2:0] <= 3'h0;
        prio[5:3] <= 3'h2;
        prio[8:6] <= 3'h1;
        prio[11:9] <= 3'h0;
        en[3] <= 1'b0;
        nap(EMAP_MODE1, 1'b0, 13, 1'b1);
        nap(EMAP_MODE2, 1'b0, 13, 1'b0);
        nap(EMAP_MODE2, 1'b0, 54, 1'b0);
        nap(EMAP_MODE2, 1'b0, 10, 1'b1);
        nap(EMAP_MODE3, 1'b1, 3, 1'b0);
        nap(EMAP_MODE3, 1'b1, 1, 1'b0);
        nap(EMAP_MODE3, 1'b1, 2, 1'b1);
        // A stricter handler level now shuts out the same source.
        @(posedge i_clk_sys);
        aprio <= 3'h1;
        nap(EMAP_MODE3, 1'b1, 2, 1'b0);
        nap(EMAP_MODE3, 1'b0, 0, 1'b1);
        look(1);
        chk(wakes, 4);
        give_verdict();
    end
endmodule
bind emap_top emap_top_checker u_chk (.*);
`default_nettype wire
